// ### common/aows_pkg.sv
// Package: constants and types of the waveform sequencer
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package aows_pkg;
	// Word addresses on the register bus
	localparam logic [2:0] A_CTRL = 3'h0;
	localparam logic [2:0] A_CMD = 3'h1;
	localparam logic [2:0] A_STAT = 3'h2;
	localparam logic [2:0] A_CNT = 3'h3;
	localparam logic [2:0] A_DIV = 3'h4;
	localparam logic [2:0] A_DLY = 3'h5;
	localparam logic [2:0] A_FIFO = 3'h6;
	localparam logic [2:0] A_DIRECT = 3'h7;
	localparam logic [2:0] A_RANGE = 3'h0;
	// Control field positions
	localparam int TM_LO = 0;
	localparam int CONT_B = 2;
	localparam int RG_LO = 3;
	localparam int EXT_B = 5;
	localparam int SS_LO = 6;
	localparam int PSRC_B = 8;
	localparam int PLOW_B = 9;
	localparam int RSEL_B = 10;
	// Command bits, write one to act
	localparam int C_START = 0;
	localparam int C_STOP = 1;
	localparam int C_UPD = 2;
	localparam int C_CLR = 3;
	// Status bit positions
	localparam int S_RUN = 0;
	localparam int S_ARM = 1;
	localparam int S_UNDF = 2;
	localparam int S_EMPTY = 3;
	localparam int S_FULL = 4;
	localparam int S_PAUSE = 5;
	localparam int S_LVL = 8;
	// Per-channel selection field layout
	localparam int SEL_W = 3;
	localparam int SEL_STRIDE = 8;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] CNT_RST = 32'h0000_0001;
	localparam logic [31:0] DIV_RST = 32'h0000_0028;
	localparam logic [31:0] DLY_RST = 32'h0000_0002;
	typedef enum logic [1:0] {TM_SW = 2'h0, TM_HWD = 2'h1,
		TM_BUF = 2'h2} aows_tm_e;
	typedef enum logic [1:0] {RG_STD = 2'h0, RG_FIFO = 2'h1,
		RG_NONE = 2'h2} aows_rg_e;
	typedef enum logic [1:0] {SS_SW = 2'h0, SS_DIG = 2'h1,
		SS_ANA = 2'h2} aows_ss_e;
	typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_ARM = 2'h1,
		ST_DLY = 2'h3, ST_RUN = 2'h2} aows_st_e;
endpackage

// ### rtl/aows_top.sv
// Waveform sequencer core with Avalon-MM register slave
//
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
module aows_top #(
	parameter int NCH = 4,
	parameter int DW = 8,
	parameter int DEPTH = 16,
	parameter bit BASIC = 1'b0
) (
	input wire logic REF_CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic [2:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	input wire logic AVS_RANGE_SEL_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	input wire logic EXT_SCLK_IN,
	input wire logic DIG_START_IN,
	input wire logic DIG_PAUSE_IN,
	input wire logic ANA_CMP_IN,
	output logic [NCH*DW-1:0] DAC_DATA_OUT,
	output logic DAC_UPDATE_OUT,
	output logic [NCH*3-1:0] OFS_SEL_OUT,
	output logic [NCH*3-1:0] REF_SEL_OUT,
	output logic FIFO_EMPTY_OUT,
	output logic FIFO_FULL_OUT
);
	localparam int PW = $clog2(DEPTH);
	localparam int SW = NCH * DW;

	// Geometry the logic cannot serve, refused at elaboration
	if (!(NCH == 2 || NCH == 4) || SW > 32 || DEPTH < 2 ||
		DEPTH > 128 || (1 << PW) != DEPTH) begin : g_bad_geom
		$error("aows_top: unsupported parameters");
	end

	// ---------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------
	logic [3:0] s1_ff, s2_ff, sd_ff;
	// Two flops per pin, third only for edges
	always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			s1_ff <= 4'h0;
			s2_ff <= 4'h0;
			sd_ff <= 4'h0;
		end else begin
			s1_ff <= {ANA_CMP_IN, DIG_PAUSE_IN, DIG_START_IN,
				EXT_SCLK_IN};
			s2_ff <= s1_ff;
			sd_ff <= s2_ff;
		end
	end
	logic [3:0] rise;
	assign rise = s2_ff & ~sd_ff;

	// ---------------------------------------------------------
	// State
	// ---------------------------------------------------------
	logic [31:0] ctrl_ff, cnt_ff, div_ff, dly_ff, rng_ff;
	logic [31:0] nxt_ctrl, nxt_cnt, nxt_div, nxt_dly, nxt_rng;
	logic [31:0] rdata_ff, nxt_rdata;
	logic wait_ff, nxt_wait;
	logic [SW-1:0] direct_ff, nxt_direct, dac_ff, nxt_dac;
	logic upd_ff, nxt_upd, undf_ff, nxt_undf;
	aows_pkg::aows_st_e st_ff, nxt_st;
	logic [31:0] rem_ff, nxt_rem, dcnt_ff, nxt_dcnt;
	logic [31:0] divc_ff, nxt_divc;
	logic [PW-1:0] rd_ff, nxt_rd, wr_ff, nxt_wr, rp_ff, nxt_rp;
	logic [PW:0] lvl_ff, nxt_lvl;
	logic [SW-1:0] mem_ff [DEPTH];
	logic [SW-1:0] nxt_mem [DEPTH];
	logic emp_ff, nxt_emp, full_ff, nxt_full;

	// Decoded control fields
	aows_pkg::aows_tm_e tm;
	aows_pkg::aows_rg_e rg;
	aows_pkg::aows_ss_e ss;
	logic cont, ext, paused, trig, tick;
	logic acc, wr_acc, cmd_wr, fifo_wr;
	logic [31:0] bmask, wd;
	assign tm = aows_pkg::aows_tm_e'(ctrl_ff[aows_pkg::TM_LO+:2]);
	assign rg = aows_pkg::aows_rg_e'(ctrl_ff[aows_pkg::RG_LO+:2]);
	assign ss = aows_pkg::aows_ss_e'(ctrl_ff[aows_pkg::SS_LO+:2]);
	assign cont = ctrl_ff[aows_pkg::CONT_B];
	assign ext = ctrl_ff[aows_pkg::EXT_B];

	// Pause is level sensitive; analog pauses while high
	assign paused = ctrl_ff[aows_pkg::PSRC_B] ? s2_ff[3] :
		s2_ff[2] ^ ctrl_ff[aows_pkg::PLOW_B];
	// Start trigger edge from the selected source
	assign trig = (ss == aows_pkg::SS_SW) ||
		(ss == aows_pkg::SS_DIG && rise[1]) ||
		(ss == aows_pkg::SS_ANA && rise[3]);
	// One sample tick for all channels; pause masks it
	assign tick = st_ff == aows_pkg::ST_RUN && !paused &&
		(ext ? rise[0] : divc_ff == 32'h0);

	// Write takes effect on the cycle waitrequest is low
	assign acc = (AVS_READ_IN || AVS_WRITE_IN) && !wait_ff;
	assign wr_acc = acc && AVS_WRITE_IN;
	assign cmd_wr = wr_acc && AVS_ADDRESS_IN == aows_pkg::A_CMD &&
		!AVS_RANGE_SEL_IN;
	assign bmask = {{8{AVS_BYTEENABLE_IN[3]}},
		{8{AVS_BYTEENABLE_IN[2]}}, {8{AVS_BYTEENABLE_IN[1]}},
		{8{AVS_BYTEENABLE_IN[0]}}};
	assign wd = AVS_WRITEDATA_IN & bmask;
	// FIFO-only replay locks the store once started
	assign fifo_wr = wr_acc && !AVS_RANGE_SEL_IN &&
		AVS_ADDRESS_IN == aows_pkg::A_FIFO && !full_ff &&
		!(tm == aows_pkg::TM_BUF && rg == aows_pkg::RG_FIFO &&
		st_ff != aows_pkg::ST_IDLE);

	// Merge byte lanes into a held register
	function automatic logic [31:0] bw(input logic [31:0] o,
		input logic [31:0] n, input logic [31:0] m);
		bw = (o & ~m) | (n & m);
	endfunction

	// ---------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------
	always_comb begin
		logic pop, push;
		pop = 1'b0;
		push = fifo_wr;
		nxt_wait = !((AVS_READ_IN || AVS_WRITE_IN) && wait_ff);
		nxt_rdata = rdata_ff;
		nxt_ctrl = ctrl_ff;
		nxt_cnt = cnt_ff;
		nxt_div = div_ff;
		nxt_dly = dly_ff;
		nxt_rng = rng_ff;
		nxt_direct = direct_ff;
		nxt_dac = dac_ff;
		nxt_upd = 1'b0;
		nxt_undf = undf_ff;
		nxt_st = st_ff;
		nxt_rem = rem_ff;
		nxt_dcnt = dcnt_ff;
		nxt_divc = divc_ff;
		nxt_rd = rd_ff;
		nxt_wr = wr_ff;
		nxt_rp = rp_ff;
		nxt_mem = mem_ff;
		// Read data staged while waitrequest is high
		if ((AVS_READ_IN || AVS_WRITE_IN) && wait_ff) begin
			nxt_rdata = 32'h0;
			if (AVS_RANGE_SEL_IN) begin
				if (AVS_ADDRESS_IN == aows_pkg::A_RANGE) begin
					nxt_rdata = rng_ff;
				end
			end else begin
				case (AVS_ADDRESS_IN)
				aows_pkg::A_CTRL: nxt_rdata = ctrl_ff;
				aows_pkg::A_CNT: nxt_rdata = cnt_ff;
				aows_pkg::A_DIV: nxt_rdata = div_ff;
				aows_pkg::A_DLY: nxt_rdata = dly_ff;
				aows_pkg::A_DIRECT: nxt_rdata = 32'(direct_ff);
				aows_pkg::A_STAT: begin
					nxt_rdata = 32'(lvl_ff) << aows_pkg::S_LVL;
					nxt_rdata[aows_pkg::S_RUN] =
						st_ff == aows_pkg::ST_RUN;
					nxt_rdata[aows_pkg::S_ARM] =
						st_ff == aows_pkg::ST_ARM;
					nxt_rdata[aows_pkg::S_UNDF] = undf_ff;
					nxt_rdata[aows_pkg::S_EMPTY] = emp_ff;
					nxt_rdata[aows_pkg::S_FULL] = full_ff;
					nxt_rdata[aows_pkg::S_PAUSE] = paused;
				end
				default: nxt_rdata = 32'h0;
				endcase
			end
		end
		// Register writes
		if (wr_acc && AVS_RANGE_SEL_IN &&
			AVS_ADDRESS_IN == aows_pkg::A_RANGE) begin
			nxt_rng = bw(rng_ff, wd, bmask);
		end else if (wr_acc && !AVS_RANGE_SEL_IN) begin // Page zero: control, count, divider, delay, direct
			case (AVS_ADDRESS_IN)
			aows_pkg::A_CTRL: nxt_ctrl = bw(ctrl_ff, wd, bmask);
			aows_pkg::A_CNT: nxt_cnt = bw(cnt_ff, wd, bmask);
			aows_pkg::A_DIV: nxt_div = bw(div_ff, wd, bmask);
			aows_pkg::A_DLY: nxt_dly = bw(dly_ff, wd, bmask);
			aows_pkg::A_DIRECT: nxt_direct = SW'(bw(
				32'(direct_ff), wd, bmask));
			default: nxt_ctrl = ctrl_ff;
			endcase
		end
		// Host values go straight to the converters
		if (cmd_wr && wd[aows_pkg::C_UPD] &&
			tm == aows_pkg::TM_SW) begin
			nxt_dac = direct_ff;
			nxt_upd = 1'b1;
		end
		// Sequencer states
		case (st_ff)
		aows_pkg::ST_IDLE: begin
			if (cmd_wr && wd[aows_pkg::C_START] &&
				tm != aows_pkg::TM_SW) begin
				nxt_st = aows_pkg::ST_ARM;
				nxt_rem = cnt_ff;
				nxt_rp = rd_ff;
			end
		end
		aows_pkg::ST_ARM: begin
			if (trig && (ext || dly_ff == 32'h0)) begin
				nxt_st = aows_pkg::ST_RUN;
				nxt_divc = 32'h0;
			end else if (trig) begin
				nxt_st = aows_pkg::ST_DLY;
				nxt_dcnt = dly_ff - 32'h1;
			end
		end
		aows_pkg::ST_DLY: begin
			// Counted in REF_CLK_IN cycles
			if (dcnt_ff == 32'h0) begin
				nxt_st = aows_pkg::ST_RUN;
				nxt_divc = 32'h0;
			end else begin
				nxt_dcnt = dcnt_ff - 32'h1;
			end
		end
		aows_pkg::ST_RUN: begin
			// Divider holds while paused, resumes in place
			if (!ext && !paused) begin
				nxt_divc = (divc_ff == 32'h0) ? div_ff - 32'h1 :
					divc_ff - 32'h1;
			end
			if (tick) begin
				nxt_upd = 1'b1;
				if (tm == aows_pkg::TM_HWD) begin
					nxt_dac = direct_ff;
				end else if (rg == aows_pkg::RG_FIFO &&
					lvl_ff != '0) begin
					// Replay stored points, never consume
					nxt_dac = mem_ff[rp_ff];
					nxt_rp = (rp_ff + 1'b1 == wr_ff) ? rd_ff :
						rp_ff + 1'b1;
				end else if (lvl_ff != '0) begin
					nxt_dac = mem_ff[rd_ff];
					pop = 1'b1;
				end else if (rg == aows_pkg::RG_STD) begin
					nxt_dac = dac_ff;
				end else begin
					// Nothing new to send: error and halt
					nxt_upd = 1'b0;
					nxt_undf = 1'b1;
					nxt_st = aows_pkg::ST_IDLE;
				end
				if (!cont && nxt_st == aows_pkg::ST_RUN) begin
					nxt_rem = rem_ff - 32'h1;
					if (rem_ff <= 32'h1) begin
						nxt_st = aows_pkg::ST_IDLE;
					end
				end
			end
		end
		default: nxt_st = aows_pkg::ST_IDLE;
		endcase
		// Stop ends any mode, continuous included
		if (cmd_wr && wd[aows_pkg::C_STOP]) begin
			nxt_st = aows_pkg::ST_IDLE;
		end
		// Clear loses to a fresh underflow
		if (cmd_wr && wd[aows_pkg::C_CLR] &&
			!(tick && nxt_undf && !undf_ff)) begin
			nxt_undf = 1'b0;
		end
		// FIFO pointers
		if (push) begin
			nxt_mem[wr_ff] = AVS_WRITEDATA_IN[SW-1:0];
			nxt_wr = wr_ff + 1'b1;
		end
		if (pop) begin
			nxt_rd = rd_ff + 1'b1;
		end
		nxt_lvl = lvl_ff + (PW+1)'(push) - (PW+1)'(pop);
		nxt_emp = nxt_lvl == '0;
		nxt_full = nxt_lvl == (PW+1)'(DEPTH);
	end

	// ---------------------------------------------------------
	// Registers
	// ---------------------------------------------------------
	always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			wait_ff <= 1'b1;
			rdata_ff <= 32'h0;
			ctrl_ff <= aows_pkg::CTRL_RST;
			cnt_ff <= aows_pkg::CNT_RST;
			div_ff <= aows_pkg::DIV_RST;
			dly_ff <= aows_pkg::DLY_RST;
			rng_ff <= 32'h0;
			direct_ff <= '0;
			dac_ff <= '0;
			upd_ff <= 1'b0;
			undf_ff <= 1'b0;
			st_ff <= aows_pkg::ST_IDLE;
			rem_ff <= 32'h0;
			dcnt_ff <= 32'h0;
			divc_ff <= 32'h0;
			rd_ff <= '0;
			wr_ff <= '0;
			rp_ff <= '0;
			lvl_ff <= '0;
			mem_ff <= '{default: '0};
			emp_ff <= 1'b1;
			full_ff <= 1'b0;
		end else begin
			wait_ff <= nxt_wait;
			rdata_ff <= nxt_rdata;
			ctrl_ff <= nxt_ctrl;
			cnt_ff <= nxt_cnt;
			div_ff <= nxt_div;
			dly_ff <= nxt_dly;
			rng_ff <= nxt_rng;
			direct_ff <= nxt_direct;
			dac_ff <= nxt_dac;
			upd_ff <= nxt_upd;
			undf_ff <= nxt_undf;
			st_ff <= nxt_st;
			rem_ff <= nxt_rem;
			dcnt_ff <= nxt_dcnt;
			divc_ff <= nxt_divc;
			rd_ff <= nxt_rd;
			wr_ff <= nxt_wr;
			rp_ff <= nxt_rp;
			lvl_ff <= nxt_lvl;
			mem_ff <= nxt_mem;
			emp_ff <= nxt_emp;
			full_ff <= nxt_full;
		end
	end

	// Outputs
	assign AVS_READDATA_OUT = rdata_ff;
	assign AVS_WAITREQUEST_OUT = wait_ff;
	assign DAC_DATA_OUT = dac_ff;
	assign DAC_UPDATE_OUT = upd_ff;
	assign FIFO_EMPTY_OUT = emp_ff;
	assign FIFO_FULL_OUT = full_ff;

	// Per-channel range selection; basic part fixes both
	for (genvar ch = 0; ch < NCH; ch++) begin : g_sel
		localparam int B = ch * aows_pkg::SEL_STRIDE;
		assign OFS_SEL_OUT[ch*3+:3] = BASIC ? 3'h0 :
			rng_ff[B+:aows_pkg::SEL_W];
		assign REF_SEL_OUT[ch*3+:3] = BASIC ? 3'h0 :
			rng_ff[B+aows_pkg::SEL_W+:aows_pkg::SEL_W];
	end

	// ---------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);

	sequence s_sw_cmd;
		cmd_wr && wd[aows_pkg::C_UPD] && tm == aows_pkg::TM_SW;
	endsequence
	sequence s_dry;
		tick && tm == aows_pkg::TM_BUF && rg == aows_pkg::RG_NONE
			&& lvl_ff == '0;
	endsequence

	a_wait_one_low: assert property (!wait_ff |=> wait_ff)
		else $error("waitrequest low twice");
	a_sw_one_update: assert property (s_sw_cmd |=> upd_ff &&
		dac_ff == $past(direct_ff) ##1 !upd_ff)
		else $error("software update not single");
	a_finite_stop: assert property (tick && !cont &&
		rem_ff == 32'h1 && !undf_ff |=> st_ff == aows_pkg::ST_IDLE)
		else $error("finite run did not stop");
	a_underflow_halt: assert property (s_dry |=> undf_ff &&
		!upd_ff && st_ff == aows_pkg::ST_IDLE)
		else $error("underflow not flagged");
	a_underflow_sticky: assert property (undf_ff &&
		!(cmd_wr && wd[aows_pkg::C_CLR]) |=> undf_ff)
		else $error("underflow flag dropped");
	a_pause_masks: assert property (st_ff == aows_pkg::ST_RUN &&
		paused && !cmd_wr |=> !upd_ff)
		else $error("update while paused");
	a_delay_hold: assert property ($rose(st_ff == aows_pkg::ST_DLY)
		&& dly_ff == 32'h2 |-> st_ff == aows_pkg::ST_DLY [*2]
		##1 st_ff == aows_pkg::ST_RUN)
		else $error("start delay wrong");
	a_replay_locked: assert property (st_ff != aows_pkg::ST_IDLE &&
		tm == aows_pkg::TM_BUF && rg == aows_pkg::RG_FIFO
		|=> lvl_ff == $past(lvl_ff))
		else $error("FIFO changed during replay");
	a_pop_level: assert property (tick && tm == aows_pkg::TM_BUF &&
		rg != aows_pkg::RG_FIFO && lvl_ff != '0 && !fifo_wr
		|=> lvl_ff == $past(lvl_ff) - 1'b1 && upd_ff)
		else $error("sample did not pop");
	a_basic_fixed: assert property (BASIC |-> OFS_SEL_OUT == '0
		&& REF_SEL_OUT == '0)
		else $error("basic selection not fixed");
endmodule

// ### testbench/aows_trig_src.sv
// Partner model: start trigger and external sample clock source
`timescale 1ns/100ps
module aows_trig_src (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic go_in,
	input wire logic [3:0] npulse_in,
	output logic sclk_out,
	output logic start_out,
	output logic busy_out
);
	logic [2:0] ph;
	logic [3:0] left;
	// Pins read as low before the first edge, not as unknown
	initial {sclk_out, start_out, busy_out} = 3'h0;
	// Start edge, then pulses two high four low; clock stands low when idle
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			{ph, left, sclk_out, start_out, busy_out} <= '0;
		end else if (!busy_out) begin
			if (go_in) begin
				{busy_out, start_out} <= 2'b11;
				left <= npulse_in;
				ph <= 3'h0;
			end
		end else if (start_out) begin
			// Long start pulse so the synchronizer surely sees it
			ph <= (ph == 3'h3) ? 3'h0 : ph + 3'h1;
			start_out <= (ph != 3'h3);
		end else if (left == 4'h0) begin
			busy_out <= 1'b0;
		end else begin
			sclk_out <= (ph < 3'h2);
			ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
			left <= (ph == 3'h5) ? left - 4'h1 : left;
		end
	end
endmodule

// ### testbench/test_aows_top.sv
// Self-checking bench for the waveform sequencer
`timescale 1ns/100ps
module test_aows_top;
	localparam int LIMIT = 20000;
	logic REF_CLK_IN = 1'b0;
	logic SYS_RST_IN = 1'b1;
	logic [2:0] AVS_ADDRESS_IN = 3'h0;
	logic AVS_READ_IN = 1'b0;
	logic AVS_WRITE_IN = 1'b0;
	logic [31:0] AVS_WRITEDATA_IN = 32'h0;
	logic [3:0] AVS_BYTEENABLE_IN = 4'h0;
	logic AVS_RANGE_SEL_IN = 1'b0;
	logic DIG_PAUSE_IN = 1'b0;
	logic ANA_CMP_IN = 1'b0;
	logic src_go = 1'b0;
	logic [3:0] src_n = 4'h0;
	logic EXT_SCLK_IN, DIG_START_IN, src_busy, AVS_WAITREQUEST_OUT;
	logic DAC_UPDATE_OUT, FIFO_EMPTY_OUT, FIFO_FULL_OUT;
	logic [31:0] AVS_READDATA_OUT, DAC_DATA_OUT;
	logic [11:0] OFS_SEL_OUT, REF_SEL_OUT, b_ofs, b_ref;
	logic [31:0] dac_q[$], rd_q[$], w[0:16];
	int err_count = 0, tests_run = 0, cyc = 0, t0, t1, d2;

	// ------------------------------------------------------------
	// Clock, instances
	// ------------------------------------------------------------
	always #12.5 REF_CLK_IN = ~REF_CLK_IN;
	aows_top i_dut (.REF_CLK_IN, .SYS_RST_IN, .AVS_ADDRESS_IN,
		.AVS_READ_IN, .AVS_WRITE_IN, .AVS_WRITEDATA_IN,
		.AVS_BYTEENABLE_IN, .AVS_RANGE_SEL_IN, .AVS_READDATA_OUT,
		.AVS_WAITREQUEST_OUT, .EXT_SCLK_IN, .DIG_START_IN, .DIG_PAUSE_IN,
		.ANA_CMP_IN, .DAC_DATA_OUT, .DAC_UPDATE_OUT, .OFS_SEL_OUT,
		.REF_SEL_OUT, .FIFO_EMPTY_OUT, .FIFO_FULL_OUT);
	// Basic variant shares the bus; only its selections are watched
	aows_top #(.BASIC(1'b1)) i_basic (.REF_CLK_IN, .SYS_RST_IN,
		.AVS_ADDRESS_IN, .AVS_READ_IN, .AVS_WRITE_IN, .AVS_WRITEDATA_IN,
		.AVS_BYTEENABLE_IN, .AVS_RANGE_SEL_IN, .AVS_READDATA_OUT(),
		.AVS_WAITREQUEST_OUT(), .EXT_SCLK_IN, .DIG_START_IN, .DIG_PAUSE_IN,
		.ANA_CMP_IN, .DAC_DATA_OUT(), .DAC_UPDATE_OUT(),
		.OFS_SEL_OUT(b_ofs), .REF_SEL_OUT(b_ref), .FIFO_EMPTY_OUT(),
		.FIFO_FULL_OUT());
	aows_trig_src i_src (.clk_in(REF_CLK_IN), .rst_in(SYS_RST_IN),
		.go_in(src_go), .npulse_in(src_n), .sclk_out(EXT_SCLK_IN),
		.start_out(DIG_START_IN), .busy_out(src_busy));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic summarize();
		$display("mismatches=%0d comparisons=%0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_flag(input logic got, input logic exp);
		cmp_data({31'h0, got}, {31'h0, exp});
	endtask
	task automatic ticks(input int k);
		repeat (k) @(posedge REF_CLK_IN);
	endtask
	// One Avalon access, held until waitrequest is sampled low
	task automatic xfer(input logic wr, input logic pg, input logic [2:0] a,
		input logic [31:0] d, input logic [3:0] be);
		int n;
		@(posedge REF_CLK_IN);
		AVS_ADDRESS_IN <= a;
		AVS_RANGE_SEL_IN <= pg;
		AVS_WRITE_IN <= wr;
		AVS_READ_IN <= !wr;
		AVS_WRITEDATA_IN <= d;
		AVS_BYTEENABLE_IN <= be;
		n = 0;
		do begin
			@(posedge REF_CLK_IN);
			n++;
		end while (AVS_WAITREQUEST_OUT !== 1'b0 && n < 50);
		if (n >= 50) cmp_flag(1'b1, 1'b0);
		AVS_WRITE_IN <= 1'b0;
		AVS_READ_IN <= 1'b0;
	endtask
	task automatic wreg(input logic [2:0] a, input logic [31:0] d);
		xfer(1'b1, 1'b0, a, d, 4'hF);
	endtask
	task automatic rreg(input logic pg, input logic [2:0] a,
		input logic [31:0] e);
		rd_q.push_back(e);
		xfer(1'b0, pg, a, 32'h0, 4'hF);
	endtask
	// Bounded wait for the next converter update
	task automatic wait_upd(output int t);
		int n;
		n = 0;
		do begin
			@(posedge REF_CLK_IN);
			n++;
		end while (DAC_UPDATE_OUT !== 1'b1 && n < 400);
		t = cyc;
		if (n >= 400) cmp_flag(1'b0, 1'b1);
	endtask
	task automatic trig(input logic [3:0] k);
		@(posedge REF_CLK_IN);
		src_go <= 1'b1;
		src_n <= k;
		@(posedge REF_CLK_IN);
		src_go <= 1'b0;
	endtask

	// ------------------------------------------------------------
	// Monitor: oldest note against each result, plus run limit
	// ------------------------------------------------------------
	always @(posedge REF_CLK_IN) begin
		if (!SYS_RST_IN && AVS_READ_IN && AVS_WAITREQUEST_OUT === 1'b0)
			cmp_data(AVS_READDATA_OUT, rd_q.size() ? rd_q.pop_front() : 'x);
		// An update with no note pending fails on the unknown value
		if (!SYS_RST_IN && DAC_UPDATE_OUT === 1'b1)
			cmp_data(DAC_DATA_OUT, dac_q.size() ? dac_q.pop_front() : 'x);
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			err_count++;
			summarize();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h7583bc0e));
		for (int i = 0; i < 17; i++) w[i] = $urandom();
		ticks(6);
		SYS_RST_IN <= 1'b0;
		cmp_flag(FIFO_EMPTY_OUT, 1'b1);
		cmp_flag(FIFO_FULL_OUT, 1'b0);
		rreg(1'b0, aows_pkg::A_CTRL, aows_pkg::CTRL_RST);
		rreg(1'b0, aows_pkg::A_CNT, aows_pkg::CNT_RST);
		rreg(1'b0, aows_pkg::A_DIV, aows_pkg::DIV_RST);
		rreg(1'b0, aows_pkg::A_DLY, aows_pkg::DLY_RST);
		rreg(1'b0, aows_pkg::A_STAT, 32'h8);
		rreg(1'b1, 3'h3, 32'h0);
		// Unmapped range-page word must not reach page zero
		xfer(1'b1, 1'b1, 3'h3, 32'h5, 4'hF);
		rreg(1'b0, aows_pkg::A_CNT, aows_pkg::CNT_RST);
		// Selections: each channel from its own byte; lane mask
		xfer(1'b1, 1'b1, aows_pkg::A_RANGE, 32'h0E1A2135, 4'hF);
		xfer(1'b1, 1'b1, aows_pkg::A_RANGE, 32'hFFFFFF0F, 4'h1);
		ticks(2);
		cmp_data({20'h0, OFS_SEL_OUT}, {20'h0, 12'o6217});
		cmp_data({20'h0, REF_SEL_OUT}, {20'h0, 12'o1341});
		cmp_data({8'h0, b_ofs, b_ref}, 32'h0);
		rreg(1'b1, aows_pkg::A_RANGE, 32'h0E1A210F);
		// Software timed: one command, one update
		for (int i = 0; i < 2; i++) begin
			wreg(aows_pkg::A_DIRECT, w[i]);
			dac_q.push_back(w[i]);
			wreg(aows_pkg::A_CMD, 32'h4);
		end
		// Buffered finite, start delay 2 then 6, divider 3
		wreg(aows_pkg::A_CTRL, 32'h2);
		wreg(aows_pkg::A_DIV, 32'h3);
		for (int k = 0; k < 2; k++) begin
			wreg(aows_pkg::A_DLY, k ? 32'h6 : 32'h2);
			wreg(aows_pkg::A_CNT, k ? 32'h2 : 32'h3);
			for (int i = 0; i < (k ? 1 : 3); i++) begin
				wreg(aows_pkg::A_FIFO, w[i]);
				dac_q.push_back(w[i]);
			end
			// Two samples from one point: empty store repeats it
			if (k) dac_q.push_back(w[0]);
			wreg(aows_pkg::A_CMD, 32'h1);
			t0 = cyc;
			wait_upd(t1);
			if (k == 0) begin
				d2 = t1 - t0;
				wait_upd(t0);
				cmp_data(t0 - t1, 32'd3);
				wait_upd(t1);
			end else begin
				cmp_data(t1 - t0 - d2, 32'd4);
			end
			ticks(20);
			rreg(1'b0, aows_pkg::A_STAT, 32'h8);
		end
		// Non-regeneration: fill past full, drain, underflow
		wreg(aows_pkg::A_DIV, 32'h2);
		wreg(aows_pkg::A_CTRL, 32'h16);
		for (int i = 0; i < 17; i++) begin
			wreg(aows_pkg::A_FIFO, w[i]);
			if (i < 16) dac_q.push_back(w[i]);
		end
		cmp_flag(FIFO_FULL_OUT, 1'b1);
		rreg(1'b0, aows_pkg::A_STAT, 32'h1010);
		wreg(aows_pkg::A_CMD, 32'h1);
		repeat (16) wait_upd(t1);
		ticks(20);
		cmp_flag(FIFO_EMPTY_OUT, 1'b1);
		rreg(1'b0, aows_pkg::A_STAT, 32'hC);
		wreg(aows_pkg::A_CMD, 32'h8);
		rreg(1'b0, aows_pkg::A_STAT, 32'h8);
		// Direct hardware timing on external clock, digital pause
		wreg(aows_pkg::A_CTRL, 32'h65);
		wreg(aows_pkg::A_DIRECT, w[5]);
		wreg(aows_pkg::A_FIFO, w[9]);
		wreg(aows_pkg::A_CMD, 32'h1);
		repeat (3) dac_q.push_back(w[5]);
		trig(4'h3);
		repeat (3) wait_upd(t1);
		ticks(10);
		DIG_PAUSE_IN <= 1'b1;
		ticks(6);
		trig(4'h2);
		ticks(40);
		DIG_PAUSE_IN <= 1'b0;
		ticks(6);
		dac_q.push_back(w[5]);
		trig(4'h1);
		wait_upd(t1);
		wreg(aows_pkg::A_CMD, 32'h2);
		// Direct timing left the queued point untouched
		rreg(1'b0, aows_pkg::A_STAT, 32'h100);
		// Active-low pause reads paused while the pin is low
		wreg(aows_pkg::A_CTRL, 32'h200);
		rreg(1'b0, aows_pkg::A_STAT, 32'h120);
		// Analog start and pause, internal clock, finite two
		wreg(aows_pkg::A_CTRL, 32'h181);
		wreg(aows_pkg::A_CNT, 32'h2);
		wreg(aows_pkg::A_DLY, 32'h0);
		wreg(aows_pkg::A_DIRECT, w[6]);
		wreg(aows_pkg::A_CMD, 32'h1);
		rreg(1'b0, aows_pkg::A_STAT, 32'h102);
		ANA_CMP_IN <= 1'b1;
		ticks(30);
		rreg(1'b0, aows_pkg::A_STAT, 32'h121);
		repeat (2) dac_q.push_back(w[6]);
		ANA_CMP_IN <= 1'b0;
		repeat (2) wait_upd(t1);
		// FIFO-only replay refuses a write, then stop
		wreg(aows_pkg::A_CTRL, 32'h0E);
		wreg(aows_pkg::A_DIV, 32'd40);
		for (int i = 0; i < 3; i++) wreg(aows_pkg::A_FIFO, w[10 + i]);
		// The point queued during direct timing leads the loop
		for (int i = 0; i < 7; i++) dac_q.push_back(w[9 + i % 4]);
		wreg(aows_pkg::A_CMD, 32'h1);
		wait_upd(t1);
		wreg(aows_pkg::A_FIFO, w[16]);
		repeat (6) wait_upd(t1);
		wreg(aows_pkg::A_CMD, 32'h2);
		ticks(100);
		// Second reset after the stop clears state
		SYS_RST_IN <= 1'b1;
		ticks(2);
		SYS_RST_IN <= 1'b0;
		ticks(1);
		cmp_flag(FIFO_EMPTY_OUT, 1'b1);
		rreg(1'b0, aows_pkg::A_CTRL, aows_pkg::CTRL_RST);
		ticks(4);
		summarize();
	end
endmodule
